/* File: logic/cfe_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module cfe_gate #(
  parameter int STATUS_WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_rst_n,
  input wire logic [STATUS_WIDTH-1:0] main_interrupt_status,
  input wire logic pme_status,
  output logic int_n,
  output logic cstschg,
  output logic irq
);
  import cfe_pkg::*;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic hit_mask;
  logic hit_event;
  logic hit_force;
  logic hit_ctrl;
  logic hit_istat;
  logic hit_imask;
  logic hit_state;
  logic mapped;
  always_comb begin
    wr_en = psel & penable & pwrite;
    rd_en = psel & penable & ~pwrite;
    hit_mask = 1'b0;
    hit_event = 1'b0;
    hit_force = 1'b0;
    hit_ctrl = 1'b0;
    hit_istat = 1'b0;
    hit_imask = 1'b0;
    hit_state = 1'b0;
    if (paddr == CFE_OFS_MASK) begin
      hit_mask = 1'b1;
    end else if (paddr == CFE_OFS_EVENT) begin
      hit_event = 1'b1;
    end else if (paddr == CFE_OFS_FORCE) begin
      hit_force = 1'b1;
    end else if (paddr == CFE_OFS_STATE) begin
      hit_state = 1'b1;
    end else if (paddr == CFE_OFS_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (paddr == CFE_OFS_IRQ_STAT) begin
      hit_istat = 1'b1;
    end else if (paddr == CFE_OFS_IRQ_MASK) begin
      hit_imask = 1'b1;
    end
    mapped = hit_mask | hit_event | hit_force | hit_state | hit_ctrl | hit_istat | hit_imask;
  end

  // ------------------------------------------------------------
  // control and mask registers
  // ------------------------------------------------------------
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] imask_q;
  logic [31:0] imask_d;
  logic func_en;
  always_comb begin
    func_en = ctrl_q[CFE_BIT_CARD_EN] & ctrl_q[CFE_BIT_FUNC_EN];
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    if (wr_en && hit_mask && func_en) begin
      mask_d = pwdata & CFE_MASK_FIELDS;
    end
    if (wr_en && hit_ctrl) begin
      ctrl_d = pwdata & CFE_CTRL_FIELDS;
    end
    if (wr_en && hit_imask) begin
      imask_d = pwdata & CFE_IRQ_FIELDS;
    end
  end
  // bus_rst_n is not in the reset list, so masks survive it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= CFE_RST_ZERO;
      ctrl_q <= CFE_RST_ZERO;
      imask_q <= CFE_RST_ZERO;
    end else begin
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
    end
  end

  // ------------------------------------------------------------
  // present state
  // ------------------------------------------------------------
  logic st_fint_q;
  logic st_fint_d;
  logic st_genwake_q;
  logic st_genwake_d;
  always_comb begin
    st_fint_d = |main_interrupt_status;
    st_genwake_d = pme_status;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_fint_q <= 1'b0;
      st_genwake_q <= 1'b0;
    end else begin
      st_fint_q <= st_fint_d;
      st_genwake_q <= st_genwake_d;
    end
  end

  // ------------------------------------------------------------
  // function event register
  // ------------------------------------------------------------
  logic genwake_rise;
  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  logic [1:0] ev_q;
  cfe_rise_det u_rise (
    .pclk(pclk),
    .presetn(presetn),
    .level(st_genwake_q),
    .rise(genwake_rise)
  );
  always_comb begin
    ev_set = 2'b00;
    ev_clr = 2'b00;
    if (wr_en && hit_force && func_en) begin
      ev_set[1] = pwdata[CFE_BIT_FUNC_INT];
      ev_set[0] = pwdata[CFE_BIT_GEN_WAKEUP];
    end
    ev_set[0] = ev_set[0] | (genwake_rise & func_en);
    if (wr_en && hit_event && func_en) begin
      ev_clr[1] = pwdata[CFE_BIT_FUNC_INT];
      ev_clr[0] = pwdata[CFE_BIT_GEN_WAKEUP];
    end
  end
  cfe_sticky #(
    .WIDTH(2)
  ) u_event (
    .pclk(pclk),
    .presetn(presetn),
    .set(ev_set),
    .clr(ev_clr),
    .q(ev_q)
  );

  // ------------------------------------------------------------
  // output gating
  // ------------------------------------------------------------
  logic powered;
  logic fint_src;
  logic fint_ok;
  logic wake_any;
  logic int_n_d;
  logic cst_d;
  logic int_n_q;
  logic cst_q;
  always_comb begin
    powered = ctrl_q[CFE_BIT_POWERED];
    fint_src = st_fint_q | ev_q[1];
    fint_ok = func_en & mask_q[CFE_BIT_FUNC_INT] & fint_src;
    wake_any = func_en & mask_q[CFE_BIT_WAKE_MASTER] &
               ((mask_q[CFE_BIT_GEN_WAKEUP] & ev_q[0]) |
                (~powered & fint_ok));
    int_n_d = ~(fint_ok & powered);
    cst_d = wake_any;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_n_q <= 1'b1;
      cst_q <= 1'b0;
    end else begin
      int_n_q <= int_n_d;
      cst_q <= cst_d;
    end
  end
  assign int_n = int_n_q;
  assign cstschg = cst_q;

  // ------------------------------------------------------------
  // block interrupt: bit1 interrupt edge, bit0 wake edge
  // ------------------------------------------------------------
  logic [1:0] is_set;
  logic [1:0] is_clr;
  logic [1:0] is_q;
  logic irq_q;
  logic irq_d;
  always_comb begin
    is_set = {(~int_n_d & int_n_q), (cst_d & ~cst_q)};
    is_clr = (wr_en && hit_istat) ? pwdata[1:0] : 2'b00;
    irq_d = |(is_q & imask_q[1:0]);
  end
  cfe_sticky #(
    .WIDTH(2)
  ) u_istat (
    .pclk(pclk),
    .presetn(presetn),
    .set(is_set),
    .clr(is_clr),
    .q(is_q)
  );
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end
  assign irq = irq_q;

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic err_d;
  logic err_q;
  // captured in setup, shown only in the single access cycle
  always_comb begin
    rdata_d = CFE_RST_ZERO;
    err_d = 1'b0;
    if (psel && !penable) begin
      err_d = ~mapped;
      if (!pwrite && func_en && hit_mask) begin
        rdata_d = mask_q;
      end else if (!pwrite && func_en && hit_event) begin
        rdata_d[CFE_BIT_FUNC_INT] = ev_q[1];
        rdata_d[CFE_BIT_GEN_WAKEUP] = ev_q[0];
      end else if (!pwrite && func_en && hit_state) begin
        rdata_d[CFE_BIT_FUNC_INT] = st_fint_q;
        rdata_d[CFE_BIT_GEN_WAKEUP] = st_genwake_q;
      end else if (!pwrite && hit_ctrl) begin
        rdata_d = ctrl_q;
      end else if (!pwrite && hit_istat) begin
        rdata_d[1:0] = is_q;
      end else if (!pwrite && hit_imask) begin
        rdata_d = imask_q;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= CFE_RST_ZERO;
      err_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end
  assign prdata = rdata_q;
  assign pslverr = err_q;

  // ------------------------------------------------------------
  // bus response
  // ------------------------------------------------------------
  logic pready_q;
  // zero wait states: every access completes in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b1;
    end else begin
      pready_q <= 1'b1;
    end
  end
  assign pready = pready_q;
  logic unused_rd;
  assign unused_rd = rd_en & bus_rst_n;
endmodule : cfe_gate
`default_nettype wire

/* File: logic/cfe_pkg.sv */
package cfe_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] CFE_OFS_EVENT = 8'hf0;
  localparam logic [7:0] CFE_OFS_MASK = 8'hf4;
  localparam logic [7:0] CFE_OFS_STATE = 8'hf8;
  localparam logic [7:0] CFE_OFS_FORCE = 8'hfc;
  localparam logic [7:0] CFE_OFS_CTRL = 8'he0;
  localparam logic [7:0] CFE_OFS_IRQ_STAT = 8'he4;
  localparam logic [7:0] CFE_OFS_IRQ_MASK = 8'he8;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CFE_BIT_FUNC_INT = 15;
  localparam int CFE_BIT_WAKE_MASTER = 14;
  localparam int CFE_BIT_GEN_WAKEUP = 4;
  localparam int CFE_BIT_CARD_EN = 3;
  localparam int CFE_BIT_FUNC_EN = 1;
  localparam int CFE_BIT_POWERED = 0;
  localparam logic [31:0] CFE_MASK_FIELDS = 32'h0000_c010;
  localparam logic [31:0] CFE_EVT_FIELDS = 32'h0000_8010;
  localparam logic [31:0] CFE_CTRL_FIELDS = 32'h0000_000b;
  localparam logic [31:0] CFE_IRQ_FIELDS = 32'h0000_0003;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] CFE_RST_ZERO = 32'h0000_0000;
endpackage : cfe_pkg

/* File: logic/cfe_rise_det.sv */
`timescale 1ns/1ps
`default_nettype none
module cfe_rise_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  output logic rise
);
  logic prev_q;
  logic prev_d;
  always_comb begin
    prev_d = level;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end
  assign rise = level & ~prev_q;
endmodule : cfe_rise_det
`default_nettype wire

/* File: logic/cfe_sticky.sv */
`timescale 1ns/1ps
`default_nettype none
module cfe_sticky #(
  parameter int WIDTH = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] q_d;
  // set wins over a clear in the same cycle
  always_comb begin
    q_d = (q & ~clr) | set;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= q_d;
    end
  end
endmodule : cfe_sticky
`default_nettype wire

/* File: test/cfe_gate_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module cfe_gate_properties
  import cfe_pkg::*;
#(
  parameter int STATUS_WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [STATUS_WIDTH-1:0] main_interrupt_status,
  input wire logic pme_status,
  input wire logic int_n,
  input wire logic cstschg,
  input wire logic irq
);
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic acc;
  logic wr;
  logic mapped;
  logic pend;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign pend = |main_interrupt_status;
  assign mapped = paddr inside {CFE_OFS_EVENT, CFE_OFS_MASK, CFE_OFS_STATE, CFE_OFS_FORCE,
    CFE_OFS_CTRL, CFE_OFS_IRQ_STAT, CFE_OFS_IRQ_MASK};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  pready_high_a: assert property (pready) else $error("pready low");
  err_phase_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("stray pslverr");
  err_data_a: assert property (acc && !mapped && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  int_fall_a: assert property ($fell(int_n) |-> $past(pend, 2) || $past(wr)
    || $past(wr, 2) || $past(wr, 3)) else $error("int_n fell without cause");
  int_rise_a: assert property ($rose(int_n) |-> !$past(pend, 2) || $past(wr)
    || $past(wr, 2) || $past(wr, 3)) else $error("int_n rose while pending");
  wake_rise_a: assert property ($rose(cstschg) |-> $past(pend, 2) || $past(pme_status, 2)
    || $past(pme_status, 3) || $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("cstschg rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
    else $error("irq fell without write");
endmodule : cfe_gate_properties
bind cfe_gate cfe_gate_properties #(.STATUS_WIDTH(STATUS_WIDTH)) cfe_gate_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .main_interrupt_status(main_interrupt_status), .pme_status(pme_status),
  .int_n(int_n), .cstschg(cstschg), .irq(irq));
`default_nettype wire

/* File: test/cfe_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cfe_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wake_req,
  input wire logic pme_clr,
  output logic pme_status
);
  // ------------------------------------------------------------
  // sticky power-management status, cleared by software
  // ------------------------------------------------------------
  logic pme_q;
  logic pme_d;
  assign pme_status = pme_q;
  always_comb pme_d = (pme_q | wake_req) & ~pme_clr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pme_q <= 1'b0;
    end else begin
      pme_q <= pme_d;
    end
  end
endmodule : cfe_host_model
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cfe_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bus_rst_n = 1'b1;
  logic [15:0] main_status = 16'h0000;
  logic wake_req = 1'b0;
  logic pme_clr = 1'b0;
  logic pme_status;
  logic int_n;
  logic cstschg;
  logic irq;
  logic [32:0] exp_q[$];
  logic [32:0] exp_rd;
  logic [2:0] pin_q[$];
  logic pin_look = 1'b0;
  int miscompares = 0;
  int checked = 0;
  always #50 pclk = ~pclk;
  cfe_gate #(.STATUS_WIDTH(16)) cfe_gate_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_rst_n(bus_rst_n),
    .main_interrupt_status(main_status),
    .pme_status(pme_status), .int_n(int_n), .cstschg(cstschg), .irq(irq));
  cfe_host_model cfe_host_model_inst (.pclk(pclk), .presetn(presetn), .wake_req(wake_req),
    .pme_clr(pme_clr), .pme_status(pme_status));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic pins(input logic [2:0] e);
    repeat (2) @(posedge pclk);
    pin_q.push_back(e);
    pin_look <= 1'b1;
    @(posedge pclk);
    pin_look <= 1'b0;
  endtask : pins
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // ------------------------------------------------------------
  // read monitor and watchdog
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready) begin
      exp_rd = exp_q.pop_front();
      check(prdata, exp_rd[31:0]);
      check({31'h0, pslverr}, {31'h0, exp_rd[32]});
    end
    if (pin_look) begin
      check({29'h0, int_n, cstschg, irq}, {29'h0, pin_q.pop_front()});
    end
  end
  initial begin
    repeat (3000) @(posedge pclk);
    miscompares++;
    end_sim();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(30460));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(CFE_OFS_MASK, 32'hffff_ffff);
    rd(CFE_OFS_MASK, 32'h0000_0000);
    wr(CFE_OFS_CTRL, 32'h0000_000b);
    wr(CFE_OFS_MASK, 32'hffff_ffff);
    rd(CFE_OFS_MASK, CFE_MASK_FIELDS);
    bus_rst_n <= 1'b0;
    repeat (3) @(posedge pclk);
    bus_rst_n <= 1'b1;
    rd(CFE_OFS_MASK, CFE_MASK_FIELDS);
    rd(8'h00, 32'h0000_0000, 1'b1);
    $display("end of test 1");
    main_status <= 16'($urandom()) | 16'h0001;
    pins(3'b000);
    rd(CFE_OFS_STATE, 32'h0000_8000);
    wr(CFE_OFS_STATE, 32'hffff_ffff);
    rd(CFE_OFS_STATE, 32'h0000_8000);
    main_status <= 16'h0000;
    pins(3'b100);
    rd(CFE_OFS_STATE, 32'h0000_0000);
    wr(CFE_OFS_MASK, 32'h0000_4010);
    main_status <= 16'($urandom()) | 16'h0001;
    pins(3'b100);
    main_status <= 16'h0000;
    $display("end of test 2");
    wr(CFE_OFS_MASK, 32'h0000_c010);
    wr(CFE_OFS_FORCE, 32'h0000_8000);
    pins(3'b000);
    rd(CFE_OFS_EVENT, 32'h0000_8000);
    rd(CFE_OFS_STATE, 32'h0000_0000);
    wr(CFE_OFS_EVENT, 32'h0000_0000);
    rd(CFE_OFS_EVENT, 32'h0000_8000);
    wr(CFE_OFS_EVENT, 32'h0000_8000);
    pins(3'b100);
    $display("end of test 3");
    wr(CFE_OFS_MASK, 32'h0000_4000);
    wake_req <= 1'b1;
    pins(3'b100);
    wake_req <= 1'b0;
    rd(CFE_OFS_STATE, 32'h0000_0010);
    rd(CFE_OFS_EVENT, 32'h0000_0010);
    wr(CFE_OFS_MASK, 32'h0000_4010);
    pins(3'b110);
    wr(CFE_OFS_MASK, 32'h0000_0010);
    pins(3'b100);
    rd(CFE_OFS_STATE, 32'h0000_0010);
    pme_clr <= 1'b1;
    pins(3'b100);
    pme_clr <= 1'b0;
    rd(CFE_OFS_STATE, 32'h0000_0000);
    wr(CFE_OFS_EVENT, 32'h0000_0010);
    $display("end of test 4");
    wr(CFE_OFS_CTRL, 32'h0000_000a);
    wr(CFE_OFS_MASK, 32'h0000_c000);
    main_status <= 16'($urandom()) | 16'h0001;
    pins(3'b110);
    wr(CFE_OFS_MASK, 32'h0000_8000);
    pins(3'b100);
    main_status <= 16'h0000;
    $display("end of test 5");
    wr(CFE_OFS_IRQ_STAT, CFE_IRQ_FIELDS);
    wr(CFE_OFS_IRQ_MASK, CFE_IRQ_FIELDS);
    wr(CFE_OFS_CTRL, 32'h0000_000b);
    pins(3'b100);
    wr(CFE_OFS_FORCE, 32'h0000_8000);
    pins(3'b001);
    wr(CFE_OFS_IRQ_MASK, 32'h0000_0000);
    pins(3'b000);
    wr(CFE_OFS_IRQ_MASK, 32'h0000_0002);
    pins(3'b001);
    wr(CFE_OFS_IRQ_STAT, CFE_IRQ_FIELDS);
    pins(3'b000);
    $display("end of test 6");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
